// ===== src/servo_alarm_pkg.sv
package servo_alarm_pkg;

    // ----------------------------------------
    // clock and indicator timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int FLASH_PHASE_MS = 250; // on or off time of one flash
    localparam int FLASH_PHASE_CYCLES = (CLK_HZ / 1000) * FLASH_PHASE_MS;
    localparam logic [3:0] GAP_PHASES = 4'h4; // dark phases between rounds

    // ----------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CAUTION_SEL = 8'h00;
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // ----------------------------------------
    // field layouts and reset values
    // ----------------------------------------
    localparam int WARN_W = 5;
    localparam int WARN_TORQUE_LIMIT = 0;
    localparam int WARN_ZERO_SPEED = 1;
    localparam int WARN_REGEN = 2;
    localparam int WARN_OVERLOAD = 3;
    localparam int WARN_FAN = 4;
    localparam logic [WARN_W-1:0] CAUTION_SEL_RESET = 5'h1f;

    localparam int CMD_PANEL_CLEAR = 0;

    localparam int ST_LATCHED = 0;
    localparam int ST_WARNING = 1;
    localparam int ST_DRIVE_ON = 2;
    localparam int ST_LOCKED = 3;
    localparam int ST_CODE_LSB = 8;
    localparam int ST_WARN_LSB = 16;

    localparam int IRQ_W = 4;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_WARN = 1;
    localparam int IRQ_CLEARED = 2;
    localparam int IRQ_REFUSED = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] tens;
        logic [3:0] ones;
    } bcd_code_s;

    typedef struct packed {
        logic valid;
        bcd_code_s code;
    } fault_event_s;

    // codes that only a power cycle releases
    function automatic logic power_cycle_only(input bcd_code_s c);
        case (c)
            8'h14, 8'h15, 8'h18, 8'h21, 8'h23, 8'h36,
            8'h37, 8'h48, 8'h49, 8'h95, 8'h96: power_cycle_only = 1'b1;
            default: power_cycle_only = 1'b0;
        endcase
    endfunction

endpackage

// ===== src/flash_sequencer.sv
`timescale 1ns/1ps

// ----------------------------------------
// two-colour flash code sequencer
// ----------------------------------------
module flash_sequencer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic tick,
    input wire logic active,
    input wire servo_alarm_pkg::bcd_code_s code,
    // lamps
    output logic led_orange,
    output logic led_red
);
    import servo_alarm_pkg::*;

    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_OR_ON = 6'b000010,
        S_OR_OFF = 6'b000100,
        S_RD_ON = 6'b001000,
        S_RD_OFF = 6'b010000,
        S_GAP = 6'b100000
    } flash_state_e;

    flash_state_e state;
    flash_state_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    // next state of the flash walk
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            S_IDLE: begin
                if (code.tens != 4'h0) begin
                    next_state = S_OR_ON;
                    next_cnt = code.tens;
                end else if (code.ones != 4'h0) begin
                    next_state = S_RD_ON;
                    next_cnt = code.ones;
                end else begin
                    next_state = S_GAP;
                    next_cnt = GAP_PHASES;
                end
            end
            S_OR_ON: begin
                if (tick) begin
                    next_state = S_OR_OFF;
                end
            end
            S_OR_OFF: begin
                if (tick && cnt != 4'h1) begin
                    next_state = S_OR_ON;
                    next_cnt = cnt - 4'h1;
                end else if (tick && code.ones != 4'h0) begin
                    next_state = S_RD_ON;
                    next_cnt = code.ones;
                end else if (tick) begin
                    next_state = S_GAP;
                    next_cnt = GAP_PHASES;
                end
            end
            S_RD_ON: begin
                if (tick) begin
                    next_state = S_RD_OFF;
                end
            end
            S_RD_OFF: begin
                if (tick && cnt != 4'h1) begin
                    next_state = S_RD_ON;
                    next_cnt = cnt - 4'h1;
                end else if (tick) begin
                    next_state = S_GAP;
                    next_cnt = GAP_PHASES;
                end
            end
            S_GAP: begin
                if (tick && cnt == 4'h1) begin
                    next_state = S_IDLE;
                end else if (tick) begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        if (!active) begin
            next_state = S_IDLE;
            next_cnt = 4'h0;
        end
    end

    // state and lamp flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_IDLE;
            cnt <= 4'h0;
            led_orange <= 1'b0;
            led_red <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            led_orange <= (next_state == S_OR_ON);
            led_red <= (next_state == S_RD_ON);
        end
    end

endmodule // flash_sequencer

// ===== src/servo_alarm_manager.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps

module servo_alarm_manager #(
    parameter int FLASH_CYCLES = servo_alarm_pkg::FLASH_PHASE_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // detection logic
    input wire servo_alarm_pkg::fault_event_s fault_event,
    input wire logic [servo_alarm_pkg::WARN_W-1:0] warn_cond,
    // host pins
    input wire logic clear_pin,
    input wire logic run_pin,
    // drive, panel and interrupt outputs
    output logic fault_output,
    output logic warning_output,
    output logic power_stage_enable,
    output servo_alarm_pkg::bcd_code_s display_code,
    output logic led_alarm,
    output logic led_orange,
    output logic led_red,
    output logic irq
);
    import servo_alarm_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic clear_s1;
    logic clear_s2;
    logic clear_s3;
    logic run_s1;
    logic run_s2;
    logic latched;
    bcd_code_s code;
    logic [WARN_W-1:0] caution_select_param;
    logic [WARN_W-1:0] warn_prev;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] div_cnt;
    logic flash_tick;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops per host pin, third flop for the clear edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_s1 <= 1'b0;
            clear_s2 <= 1'b0;
            clear_s3 <= 1'b0;
            run_s1 <= 1'b0;
            run_s2 <= 1'b0;
        end else begin
            clear_s1 <= clear_pin;
            clear_s2 <= clear_s1;
            clear_s3 <= clear_s2;
            run_s1 <= run_pin;
            run_s2 <= run_s1;
        end
    end

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire setup_acc = psel && penable && !pready;
    wire done = psel && penable && pready;
    wire wr = done && pwrite;
    wire hit_sel = (paddr == ADDR_CAUTION_SEL);
    wire hit_cmd = (paddr == ADDR_COMMAND);
    wire hit_st = (paddr == ADDR_STATUS);
    wire hit_is = (paddr == ADDR_IRQ_STAT);
    wire hit_im = (paddr == ADDR_IRQ_MASK);
    wire hit_any = hit_sel || hit_cmd || hit_st || hit_is || hit_im;

    // ----------------------------------------
    // clear requests and fault latch
    // ----------------------------------------
    wire pin_clear = clear_s2 && !clear_s3;
    wire panel_clear = wr && hit_cmd && pwdata[CMD_PANEL_CLEAR];
    wire clear_req = pin_clear || panel_clear;
    wire locked = power_cycle_only(code);
    wire do_clear = latched && clear_req && !locked;
    wire refused = latched && clear_req && locked;
    wire new_fault = fault_event.valid && !latched;
    wire next_latched = new_fault || (latched && !do_clear);

    // fault latch holds the first code only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= 1'b0;
            code <= '0;
        end else begin
            latched <= next_latched;
            if (new_fault) begin
                code <= fault_event.code;
            end
        end
    end

    // ----------------------------------------
    // drive outputs
    // ----------------------------------------
    wire [WARN_W-1:0] warn_sel = warn_cond & caution_select_param;
    wire [WARN_W-1:0] warn_rise = warn_sel & ~warn_prev;

    // fault, power stage, warning and display flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_output <= 1'b0;
            power_stage_enable <= 1'b0;
            warning_output <= 1'b0;
            display_code <= '0;
            led_alarm <= 1'b0;
            warn_prev <= '0;
        end else begin
            fault_output <= next_latched;
            power_stage_enable <= run_s2 && !next_latched;
            warning_output <= |warn_sel;
            display_code <= next_latched ? (new_fault ? fault_event.code
                                                      : code) : '0;
            led_alarm <= next_latched;
            warn_prev <= warn_sel;
        end
    end

    // ----------------------------------------
    // flash rate divider and sequencer
    // ----------------------------------------
    wire div_end = (div_cnt == 32'(FLASH_CYCLES - 1));

    // one-cycle tick per flash phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 32'h0;
            flash_tick <= 1'b0;
        end else if (!latched || div_end) begin
            div_cnt <= 32'h0;
            flash_tick <= latched;
        end else begin
            div_cnt <= div_cnt + 32'h1;
            flash_tick <= 1'b0;
        end
    end

    flash_sequencer u_flash (
        .pclk(pclk),
        .presetn(presetn),
        .tick(flash_tick),
        .active(latched),
        .code(code),
        .led_orange(led_orange),
        .led_red(led_red)
    );

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    wire [IRQ_W-1:0] events = {refused, do_clear, |warn_rise, new_fault};
    wire [IRQ_W-1:0] w1c = (wr && hit_is) ? pwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~w1c) | events;

    // sticky bits, a new event beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    // select and mask registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            caution_select_param <= CAUTION_SEL_RESET;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            if (wr && hit_sel) begin
                caution_select_param <= pwdata[WARN_W-1:0];
            end
            if (wr && hit_im) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [31:0] status_word;
    logic [31:0] rdata;

    // status word and read mux
    always_comb begin
        status_word = 32'h0;
        status_word[ST_LATCHED] = latched;
        status_word[ST_WARNING] = warning_output;
        status_word[ST_DRIVE_ON] = power_stage_enable;
        status_word[ST_LOCKED] = latched && locked;
        status_word[ST_CODE_LSB +: 8] = code;
        status_word[ST_WARN_LSB +: WARN_W] = warn_cond;
        rdata = 32'h0;
        if (hit_sel) begin
            rdata[WARN_W-1:0] = caution_select_param;
        end
        if (hit_st) begin
            rdata = status_word;
        end
        if (hit_is) begin
            rdata[IRQ_W-1:0] = irq_stat;
        end
        if (hit_im) begin
            rdata[IRQ_W-1:0] = irq_mask;
        end
    end

    // one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_acc;
            prdata <= (setup_acc && !pwrite) ? rdata : 32'h0;
            pslverr <= setup_acc && !hit_any;
        end
    end

endmodule // servo_alarm_manager

// ===== test/servo_alarm_props.sv
`timescale 1ns/1ps

module servo_alarm_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // inputs
    input wire logic psel,
    input wire servo_alarm_pkg::fault_event_s fault_event,
    input wire logic [servo_alarm_pkg::WARN_W-1:0] warn_cond,
    input wire logic clear_pin,
    input wire logic run_pin,
    // outputs
    input wire logic fault_output,
    input wire logic warning_output,
    input wire logic power_stage_enable,
    input wire servo_alarm_pkg::bcd_code_s display_code,
    input wire logic led_alarm,
    input wire logic led_orange,
    input wire logic led_red
);
    import servo_alarm_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // new fault while idle, and codes only power cycling frees
    wire logic take = fault_event.valid && !fault_output;
    wire logic [7:0] shown = display_code;
    wire logic locked = shown inside {8'h14, 8'h15, 8'h18, 8'h21,
        8'h23, 8'h36, 8'h37, 8'h48, 8'h49, 8'h95, 8'h96};
    wire logic lit = led_orange || led_red;

    fault_set_a:
        assert property (take |=> fault_output && !power_stage_enable
            && display_code == $past(fault_event.code))
        else $error("fault not latched");
    power_off_a:
        assert property (fault_output |-> !power_stage_enable)
        else $error("power stage on during fault");
    warn_none_a:
        assert property (warn_cond == '0 |=> !warning_output)
        else $error("warning without condition");
    run_keep_a:
        assert property ((run_pin && !fault_output)[*5]
            |-> power_stage_enable)
        else $error("drive off while running");
    lamp_a:
        assert property (led_alarm == fault_output)
        else $error("alarm lamp wrong");
    flash_start_a:
        assert property (take && fault_event.code.tens != 4'h0
            |=> ##1 led_orange && !led_red)
        else $error("flash not starting orange");
    flash_only_a:
        assert property (lit |-> !(led_orange && led_red) && (fault_output
            || $past(fault_output) || $past(fault_output, 2)))
        else $error("flash outside fault");
    hold_a:
        assert property ((fault_output && !clear_pin && !psel)[*4]
            |=> fault_output && $stable(display_code))
        else $error("fault not held");
    locked_a:
        assert property (fault_output && locked |=> fault_output)
        else $error("locked code released");

    cover property (take);
    cover property (locked && clear_pin);
    cover property ($fell(fault_output) && run_pin);
endmodule // servo_alarm_props

// ===== test/host_model.sv
`timescale 1ns/1ps

module host_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic clr_go,
    input wire logic run_want,
    input wire logic keep_run,
    // pins
    output logic clear_pin,
    output logic run_pin
);
    logic [3:0] cnt;

    // clear sequence timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
        end else if (clr_go && cnt == 4'h0) begin
            cnt <= 4'hc;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end

    // run dropped around the clear pulse unless told to keep it
    assign run_pin = run_want && (keep_run || cnt == 4'h0);
    assign clear_pin = cnt > 4'h4 && cnt < 4'h9;
endmodule // host_model

// ===== test/servo_alarm_manager_tb_top.sv
`timescale 1ns/1ps

module servo_alarm_manager_tb_top;
    import servo_alarm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic rerr, clear_pin, run_pin, clr_go, run_want, keep_run;
    fault_event_s fault_event;
    logic [WARN_W-1:0] warn_cond;
    logic fault_output, warning_output, power_stage_enable;
    logic led_alarm, led_orange, led_red;
    bcd_code_s display_code;
    int errors, check_count;
    int cyc = 0;

    servo_alarm_manager #(.FLASH_CYCLES(4)) dut_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_event(fault_event), .warn_cond(warn_cond),
        .clear_pin(clear_pin), .run_pin(run_pin),
        .fault_output(fault_output), .warning_output(warning_output),
        .power_stage_enable(power_stage_enable),
        .display_code(display_code), .led_alarm(led_alarm),
        .led_orange(led_orange), .led_red(led_red), .irq(irq));
    host_model host_u (.pclk(pclk), .presetn(presetn), .clr_go(clr_go),
        .run_want(run_want), .keep_run(keep_run),
        .clear_pin(clear_pin), .run_pin(run_pin));

    // ----------------------------------------
    // clock, timeout and helpers
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    task automatic final_report;
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic inject(input logic [7:0] c);
        fault_event <= {1'b1, c};
        @(posedge pclk);
        fault_event <= '0;
    endtask
    // count lamp flashes of one round, ended by the long dark gap
    task automatic flash_round(input int eo, input int er);
        int o, r, dark;
        logic po, pr;
        o = 0;
        r = 0;
        dark = 0;
        po = led_orange;
        pr = led_red;
        while (!(r > 0 && dark >= 8)) begin
            @(posedge pclk);
            if (led_orange === 1'b1 && po !== 1'b1) o++;
            if (led_red === 1'b1 && pr !== 1'b1) r++;
            dark = (led_orange || led_red) ? 0 : dark + 1;
            po = led_orange;
            pr = led_red;
        end
        chk("orange_count", o, eo);
        chk("red_count", r, er);
    endtask
    task automatic pin_clear;
        clr_go <= 1'b1;
        tick(1);
        clr_go <= 1'b0;
        tick(16);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        check_count = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, clr_go, run_want, keep_run} = '0;
        paddr = '0;
        pwdata = '0;
        fault_event = '0;
        warn_cond = '0;
        tick(16);
        presetn <= 1'b1;
        // register resets, access and unmapped place
        apb(1'b0, ADDR_CAUTION_SEL, '0);
        chk("caution_sel", rdat, 32'h1f);
        apb(1'b0, ADDR_IRQ_MASK, '0);
        chk("irq_mask", rdat, 32'h0);
        apb(1'b0, 8'h20, '0);
        chk("unmapped_err", rerr, 1'b1);
        apb(1'b1, ADDR_CAUTION_SEL, 32'h15);
        apb(1'b0, ADDR_CAUTION_SEL, '0);
        chk("caution_sel_rw", rdat, 32'h15);
        // every warning kind, drive kept on
        run_want <= 1'b1;
        tick(4);
        for (int i = 0; i < WARN_W; i++) begin
            warn_cond <= WARN_W'(1 << i);
            tick(3);
            chk("warning", warning_output, (32'h15 >> i) & 1);
            chk("power_warn", power_stage_enable, 1'b1);
        end
        warn_cond <= '0;
        // clearable fault, repeated flashing, later fault dropped
        inject(8'h16);
        flash_round(1, 6);
        flash_round(1, 6);
        chk("fault_output", fault_output, 1'b1);
        chk("power_off", power_stage_enable, 1'b0);
        chk("led_alarm", led_alarm, 1'b1);
        inject(8'h12);
        tick(2);
        chk("first_code", display_code, 8'h16);
        // clear pin with run left on
        keep_run <= 1'b1;
        pin_clear();
        chk("pin_clear", fault_output, 1'b0);
        chk("power_back", power_stage_enable, 1'b1);
        keep_run <= 1'b0;
        // interrupt raise, mask, clear, then panel clear
        inject(8'h24);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        tick(1);
        chk("irq_raised", irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq_cleared", irq, 1'b0);
        apb(1'b1, ADDR_COMMAND, 32'h1);
        chk("panel_clear", fault_output, 1'b0);
        tick(1);
        chk("irq_masked", irq, 1'b0);
        // locked code refuses both clears
        inject(8'h23);
        flash_round(2, 3);
        pin_clear();
        apb(1'b1, ADDR_COMMAND, 32'h1);
        apb(1'b0, ADDR_STATUS, '0);
        chk("locked_status", rdat[3:0], 4'h9);
        chk("locked_code", rdat[15:8], 8'h23);
        apb(1'b0, ADDR_IRQ_STAT, '0);
        chk("refused_irq", rdat[3], 1'b1);
        chk("irq_stat_all", rdat[3:0], 4'hf);
        // power cycle frees it
        presetn <= 1'b0;
        tick(2);
        presetn <= 1'b1;
        tick(2);
        chk("power_cycle", fault_output, 1'b0);
        chk("code_gone", display_code, 8'h00);
        final_report();
    end
endmodule // servo_alarm_manager_tb_top

bind servo_alarm_manager servo_alarm_props chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .fault_event(fault_event),
    .warn_cond(warn_cond), .clear_pin(clear_pin), .run_pin(run_pin),
    .fault_output(fault_output), .warning_output(warning_output),
    .power_stage_enable(power_stage_enable),
    .display_code(display_code), .led_alarm(led_alarm),
    .led_orange(led_orange), .led_red(led_red));
